// *** src/pric_top.sv ***
// Module: priority interrupt controller with APB register slave
//
// Behaviour
// [R1] Each source has a 3-bit priority; 7 is the highest user level.
// [R2] Priority 0 disables the source regardless of flag and enable.
// [R3] Every source priority resets to level 4, register reads 0x0040.
// [R4] Priority register bits 15:7 and 3:0 read zero and ignore writes.
// [R5] Status bits 11:8 show the new CPU priority level, 0 to 15.
// [R6] Status bits 6:0 show pending vector minus 8.
// [R7] Status bits 15:12 and 7 read zero; fields reset to zero.
// [R8] Nesting disable stops any interrupt preempting a running handler; here only user sources are held back and a trap still preempts.
// [R9] Software writes priority, clears flag, then sets enable.
// [R10] A flag still set at return is taken again at once.
// [R11] Return restores saved program counter, low status byte and CPU level; a trap returning onto a saved level 7 with frames left keeps level 15.
// [R12] Trap flag stays set until cleared; else the trap is re-entered.
// [R13] ORing 0xE0 into the low status byte masks all user sources.
// [R14] Traps at levels 8 to 15 are never masked by CPU level.
// [R15] Timed disable blocks levels 1 to 6 for a given count.
// [R16] Level 7 sources still interrupt during the timed disable.
// [R17] Software may give all enabled sources the same nonzero priority.
// [R18] Highest-priority flagged, enabled source above CPU level interrupts.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pric_top
  import pric_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N_SRC-1:0] SRC_EVENT,
  input wire logic TRAP_EVENT,
  input wire logic [15:0] CORE_PC,
  output logic CPU_IRQ,
  output logic [6:0] CPU_VECTOR,
  output logic [15:0] RESTORE_PC,
  output logic RESTORE_VALID,
  output logic IRQ
);
  import pric_pkg::*;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  logic [N_SRC*3-1:0] prio_ff, nxt_prio;
  logic [N_SRC-1:0] flag_ff, nxt_flag;
  logic [N_SRC-1:0] enab_ff, nxt_enab;
  logic nesting_disable_ff, nxt_nesting_disable;
  logic trap_ff, nxt_trap;
  logic [7:0] slb_ff, nxt_slb;
  logic [3:0] lvl_ff, nxt_lvl;
  logic [13:0] dis_ff, nxt_dis;
  logic [3:0] ilr_ff, nxt_ilr;
  logic [6:0] vec_ff, nxt_vec;
  logic [1:0] ists_ff, nxt_ists;
  logic [1:0] imsk_ff, nxt_imsk;
  pric_state_e st_ff, nxt_st;
  // Return stack of PC and low status byte, one frame per nesting level.
  // A ninth frame is never pushed; an acknowledge with a full stack is refused
  logic [15:0] stk_pc_ff [PRIC_NEST_DEPTH];
  logic [7:0] stk_slb_ff [PRIC_NEST_DEPTH];
  logic [15:0] nxt_stk_pc [PRIC_NEST_DEPTH];
  logic [7:0] nxt_stk_slb [PRIC_NEST_DEPTH];
  logic [3:0] sp_ff, nxt_sp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic cirq_ff, nxt_cirq;
  logic rv_ff, nxt_rv;
  logic irq_ff, nxt_irq;
  logic [6:0] cvec_ff, nxt_cvec;
  logic [15:0] rpc_ff, nxt_rpc;

  // -----------------------------------------------------------------
  // Arbitration
  // -----------------------------------------------------------------
  logic found;
  logic [2:0] best_prio;
  logic [6:0] best_idx;
  logic [N_SRC-1:0] live;
  logic dis_active, user_ok, take_trap, take_user;
  logic [3:0] cur_lvl;

  // A source competes only while both its flag and its enable are set
  assign live = flag_ff & enab_ff;
  assign cur_lvl = lvl_ff;

  pric_prio_sel #(.N(N_SRC)) pric_prio_sel_inst (
    .prio(prio_ff),
    .req(live),
    .found(found),
    .best_prio(best_prio),
    .best_idx(best_idx)
  );

  // Any count left means the disable window is still open
  assign dis_active = (dis_ff != PRIC_DIS_RST);
  // A source must beat the CPU level strictly; equal levels wait
  // Timed disable lets level 7 through
  assign user_ok = found && ({1'b0, best_prio} > cur_lvl)
    && (!dis_active || best_prio == 3'h7); // [R15] [R16] [R13] [R18]
  // Traps ignore CPU level; a set trap flag re-enters its handler
  // Level 15 is held by a running trap, so it does not re-enter itself
  assign take_trap = trap_ff && (lvl_ff != PRIC_LVL_TRAP); // [R14] [R12]
  // A set flag at return simply wins arbitration again
  assign take_user = user_ok && !(nesting_disable_ff && st_ff == PRIC_SERV); // [R8] [R10]

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  logic acc, wr, rd;
  logic [31:0] cmd;
  logic src_hit;
  logic [6:0] src_i;
  // Transfers are taken on the first access cycle and PREADY follows one
  // cycle later, so every transfer has exactly one wait state
  assign acc = PSEL && PENABLE && !ready_ff;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;
  // Command bits act for one cycle only and are never stored
  assign cmd = (wr && PADDR == PRIC_OFS_CMD) ? PWDATA : 32'h0000_0000;
  assign src_hit = PADDR >= PRIC_OFS_SRC0 && PADDR[1:0] == 2'h0
    && ((PADDR - PRIC_OFS_SRC0) >> 2) < 8'(N_SRC);
  assign src_i = 7'((PADDR - PRIC_OFS_SRC0) >> 2);

  // -----------------------------------------------------------------
  // Status view
  // -----------------------------------------------------------------
  // The status field counts from the first user vector; a trap has no
  // slot there and shows as zero, its level of 15 tells it apart
  logic [6:0] vec_field;
  assign vec_field = (vec_ff >= PRIC_VEC_SRC0) ? vec_ff - PRIC_VEC_SRC0 : 7'h00; // [R6]

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    // Hold by default; answer strobes and pulses drop
    nxt_prio = prio_ff;
    nxt_flag = (flag_ff | SRC_EVENT);
    nxt_enab = enab_ff;
    nxt_nesting_disable = nesting_disable_ff;
    nxt_trap = trap_ff | TRAP_EVENT; // [R12]
    nxt_slb = slb_ff;
    nxt_lvl = lvl_ff;
    nxt_dis = dis_active ? dis_ff - 14'h0001 : dis_ff; // [R15]
    nxt_ilr = ilr_ff;
    nxt_vec = vec_ff;
    nxt_ists = ists_ff;
    nxt_imsk = imsk_ff;
    nxt_st = st_ff;
    nxt_stk_pc = stk_pc_ff;
    nxt_stk_slb = stk_slb_ff;
    nxt_sp = sp_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_ready = acc;
    nxt_err = 1'b0;
    nxt_rv = 1'b0;
    nxt_rpc = rpc_ff;

    // Unmapped offsets answer with PSLVERR and change nothing
    // Register writes; hardware sets below override clears
    if (wr) begin
      case (PADDR)
        // Source 0 also answers at the first offset
        PRIC_OFS_PRIO: nxt_prio[0 +: 3] = PWDATA[PRIC_PRIO_LSB +: 3]; // [R1] [R4]
        PRIC_OFS_STAT: ;
        PRIC_OFS_FLAG: nxt_flag = PWDATA[N_SRC-1:0] | SRC_EVENT;
        PRIC_OFS_ENAB: nxt_enab = PWDATA[N_SRC-1:0];
        PRIC_OFS_CTRL: begin
          nxt_nesting_disable = PWDATA[PRIC_CTRL_NESTING_DISABLE_BIT];
          nxt_trap = PWDATA[PRIC_CTRL_TRAP_BIT] | TRAP_EVENT; // [R12]
        end
        PRIC_OFS_CPU: begin
          nxt_slb = PWDATA[7:0];
          nxt_lvl = {1'b0, PWDATA[7:5]}; // [R13]
        end
        PRIC_OFS_CMD: ;
        PRIC_OFS_ISTS: nxt_ists = ists_ff & ~PWDATA[1:0];
        PRIC_OFS_IMSK: nxt_imsk = PWDATA[1:0];
        default: begin
          if (src_hit) begin
            nxt_prio[src_i*3 +: 3] = PWDATA[PRIC_PRIO_LSB +: 3];
          end else begin
            nxt_err = 1'b1;
          end
        end
      endcase
      // Timed-disable load, count in cycles from bits 29:16
      // A new load restarts the window; the count then runs down alone
      if (PADDR == PRIC_OFS_CMD && PWDATA[PRIC_CMD_DIS_BIT]) begin
        nxt_dis = PWDATA[29:16]; // [R15]
      end
    end

    // Reads
    // Unused bits read as zero in every word
    if (rd) begin
      case (PADDR)
        PRIC_OFS_PRIO: nxt_rdata = {25'h0, prio_ff[0 +: 3], 4'h0}; // [R4]
        PRIC_OFS_STAT: nxt_rdata = {20'h0, ilr_ff, 1'b0, vec_field}; // [R5] [R6] [R7]
        PRIC_OFS_FLAG: nxt_rdata = 32'(flag_ff);
        PRIC_OFS_ENAB: nxt_rdata = 32'(enab_ff);
        PRIC_OFS_CTRL: nxt_rdata = {16'h0, nesting_disable_ff, 14'h0, trap_ff};
        PRIC_OFS_CPU: nxt_rdata = {20'h0, lvl_ff, slb_ff};
        PRIC_OFS_CMD: nxt_rdata = {18'h0, dis_ff};
        PRIC_OFS_ISTS: nxt_rdata = {30'h0, ists_ff};
        PRIC_OFS_IMSK: nxt_rdata = {30'h0, imsk_ff};
        default: begin
          if (src_hit) begin
            nxt_rdata = {25'h0, prio_ff[src_i*3 +: 3], 4'h0};
          end else begin
            nxt_err = 1'b1;
          end
        end
      endcase
    end

    // Core handshake
    // A request stays up until acknowledged; a later, higher source waits
    case (st_ff)
      PRIC_IDLE, PRIC_SERV: begin
        if (take_trap || take_user) begin
          nxt_st = PRIC_REQ;
          nxt_ilr = take_trap ? PRIC_LVL_TRAP : {1'b0, best_prio}; // [R5]
          nxt_vec = take_trap ? PRIC_VEC_TRAP : 7'(PRIC_VEC_SRC0 + best_idx); // [R6]
        end
      end
      PRIC_REQ: begin
        // A full stack ignores the acknowledge and the request stays up
        if (cmd[PRIC_CMD_ACK_BIT] && sp_ff != 4'(PRIC_NEST_DEPTH)) begin
          // Stack PC, low status byte and level, then raise level
          nxt_stk_pc[sp_ff[2:0]] = CORE_PC;
          nxt_stk_slb[sp_ff[2:0]] = {lvl_ff[2:0], slb_ff[4:0]};
          nxt_sp = sp_ff + 4'h1;
          nxt_lvl = ilr_ff;
          // The low status byte carries the level in its top three bits
          nxt_slb = {ilr_ff[2:0], slb_ff[4:0]};
          nxt_st = PRIC_SERV;
          nxt_ists[0] = 1'b1;
        end
      end
      default: nxt_st = PRIC_IDLE;
    endcase

    // Return from handler unstacks
    // The old level applies at once, except that a trap returning onto a saved
    // level 7 with frames left keeps level 15; a flag left set is arbitrated
    // again on the very next cycle
    if (cmd[PRIC_CMD_RET_BIT] && sp_ff != 4'h0) begin
      nxt_sp = sp_ff - 4'h1;
      nxt_rpc = stk_pc_ff[nxt_sp[2:0]]; // [R11]
      nxt_slb = stk_slb_ff[nxt_sp[2:0]]; // [R11]
      nxt_lvl = (stk_slb_ff[nxt_sp[2:0]][7:5] == 3'h7 && ilr_ff == PRIC_LVL_TRAP
        && sp_ff > 4'h1) ? lvl_ff : {1'b0, stk_slb_ff[nxt_sp[2:0]][7:5]}; // [R11]
      nxt_rv = 1'b1;
      nxt_st = (sp_ff == 4'h1) ? PRIC_IDLE : PRIC_SERV;
      nxt_ists[1] = 1'b1;
    end

    nxt_cirq = (nxt_st == PRIC_REQ);
    nxt_cvec = nxt_vec;
    // Built from the next status so the interrupt lags no extra cycle
    nxt_irq = |(nxt_ists & imsk_ff);
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prio_ff <= {N_SRC{PRIC_PRIO_RST}}; // [R3]
      flag_ff <= '0;
      enab_ff <= '0;
      nesting_disable_ff <= 1'b0;
      trap_ff <= 1'b0;
      slb_ff <= 8'h00;
      lvl_ff <= 4'h0;
      dis_ff <= PRIC_DIS_RST;
      ilr_ff <= 4'h0; // [R7]
      vec_ff <= 7'h00; // [R7]
      ists_ff <= 2'h0;
      imsk_ff <= 2'h0;
      st_ff <= PRIC_IDLE;
      sp_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      cirq_ff <= 1'b0;
      cvec_ff <= 7'h00;
      rpc_ff <= 16'h0000;
      rv_ff <= 1'b0;
      irq_ff <= 1'b0;
      // Frames reset too; a return with an empty stack is ignored
      for (int i = 0; i < PRIC_NEST_DEPTH; i++) begin
        stk_pc_ff[i] <= 16'h0000;
        stk_slb_ff[i] <= 8'h00;
      end
    end else begin
      prio_ff <= nxt_prio;
      flag_ff <= nxt_flag;
      enab_ff <= nxt_enab;
      nesting_disable_ff <= nxt_nesting_disable;
      trap_ff <= nxt_trap;
      slb_ff <= nxt_slb;
      lvl_ff <= nxt_lvl;
      dis_ff <= nxt_dis;
      ilr_ff <= nxt_ilr;
      vec_ff <= nxt_vec;
      ists_ff <= nxt_ists;
      imsk_ff <= nxt_imsk;
      st_ff <= nxt_st;
      sp_ff <= nxt_sp;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      cirq_ff <= nxt_cirq;
      cvec_ff <= nxt_cvec;
      rpc_ff <= nxt_rpc;
      rv_ff <= nxt_rv;
      irq_ff <= nxt_irq;
      stk_pc_ff <= nxt_stk_pc;
      stk_slb_ff <= nxt_stk_slb;
    end
  end

  // -----------------------------------------------------------------
  // Output ports
  // -----------------------------------------------------------------
  assign PRDATA = rdata_ff;
  assign PREADY = ready_ff;
  assign PSLVERR = err_ff;
  assign CPU_IRQ = cirq_ff;
  assign CPU_VECTOR = cvec_ff;
  assign RESTORE_PC = rpc_ff;
  assign RESTORE_VALID = rv_ff;
  assign IRQ = irq_ff;
endmodule
`default_nettype wire

// *** src/pric_pkg.sv ***
// Package: register map, field layout and constants of the priority interrupt controller
package pric_pkg;
  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] PRIC_OFS_PRIO = 8'h00;   // charge_time_irq_priority
  localparam logic [7:0] PRIC_OFS_STAT = 8'h04;   // interrupt_control_status
  localparam logic [7:0] PRIC_OFS_FLAG = 8'h08;   // irq_flag_regs
  localparam logic [7:0] PRIC_OFS_ENAB = 8'h0C;   // irq_enable_regs
  localparam logic [7:0] PRIC_OFS_CTRL = 8'h10;   // irq_control_reg_one
  localparam logic [7:0] PRIC_OFS_CPU = 8'h14;    // status_low_byte (CPU level)
  localparam logic [7:0] PRIC_OFS_CMD = 8'h18;    // core command strobes
  localparam logic [7:0] PRIC_OFS_ISTS = 8'h1C;   // sticky event status, W1C
  localparam logic [7:0] PRIC_OFS_IMSK = 8'h20;   // event mask
  localparam logic [7:0] PRIC_OFS_SRC0 = 8'h40;   // per-source priority, one word each
  // -----------------------------------------------------------------
  // Field positions and values
  // -----------------------------------------------------------------
  localparam int PRIC_PRIO_LSB = 4;
  localparam logic [2:0] PRIC_PRIO_RST = 3'h4;
  localparam int PRIC_LVL_LSB = 8;
  localparam int PRIC_CTRL_NESTING_DISABLE_BIT = 15;
  localparam int PRIC_CTRL_TRAP_BIT = 0;
  localparam int PRIC_CMD_ACK_BIT = 0;
  localparam int PRIC_CMD_RET_BIT = 1;
  localparam int PRIC_CMD_DIS_BIT = 2;
  localparam logic [7:0] PRIC_MASK_OR = 8'hE0;
  localparam logic [3:0] PRIC_LVL_USER_MAX = 4'h7;
  localparam logic [3:0] PRIC_LVL_TRAP = 4'hF;
  localparam logic [6:0] PRIC_VEC_TRAP = 7'h00;
  localparam logic [6:0] PRIC_VEC_SRC0 = 7'h08;
  localparam logic [13:0] PRIC_DIS_RST = 14'h0000;
  localparam int PRIC_NEST_DEPTH = 8;
  // Core handshake states
  typedef enum logic [1:0] {PRIC_IDLE, PRIC_REQ, PRIC_SERV} pric_state_e;
endpackage

// *** src/pric_prio_sel.sv ***
// Module: picks the highest-priority requesting source
`timescale 1ns/1ns
`default_nettype none
module pric_prio_sel #(
  parameter int N = 8
) (
  input wire logic [N*3-1:0] prio,
  input wire logic [N-1:0] req,
  output logic found,
  output logic [2:0] best_prio,
  output logic [6:0] best_idx
);
  always_comb begin
    found = 1'b0;
    best_prio = 3'h0;
    best_idx = 7'h00;
    // Lowest index wins among equals
    for (int i = 0; i < N; i++) begin
      if (req[i] && prio[i*3 +: 3] != 3'h0 && (!found || prio[i*3 +: 3] > best_prio)) begin // [R2] [R18]
        found = 1'b1;
        best_prio = prio[i*3 +: 3];
        best_idx = 7'(i);
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/pric_checker.sv ***
// Checker: port-level assertions for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pric_checker
  import pric_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [N_SRC-1:0] SRC_EVENT,
  input wire logic CPU_IRQ,
  input wire logic [6:0] CPU_VECTOR,
  input wire logic RESTORE_VALID,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access phase not answered");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_prio_bits: assert property (PREADY && !PWRITE && PADDR == PRIC_OFS_PRIO
    |-> (PRDATA & 32'hFFFFFF8F) == 32'h0) else $error("priority spare bits set");
  a_stat_bits: assert property (PREADY && !PWRITE && PADDR == PRIC_OFS_STAT
    |-> PRDATA[31:12] == 20'h0 && !PRDATA[7]) else $error("status spare bits set");
  a_vec_range: assert property (CPU_IRQ |-> CPU_VECTOR == PRIC_VEC_TRAP
    || (CPU_VECTOR >= PRIC_VEC_SRC0 && CPU_VECTOR < PRIC_VEC_SRC0 + N_SRC))
    else $error("vector out of range");
  a_irq_hold: assert property (CPU_IRQ && !PSEL && !$past(PSEL) |=> CPU_IRQ)
    else $error("request dropped without ack");
  a_restore_pulse: assert property (RESTORE_VALID |=> !RESTORE_VALID)
    else $error("restore longer than one cycle");
  c_take: cover property ($rose(CPU_IRQ));
  c_return: cover property (RESTORE_VALID);
  c_error: cover property (PSLVERR);
  c_event: cover property (IRQ && |SRC_EVENT);
endmodule
bind pric_top pric_checker #(.N_SRC(N_SRC)) pric_checker_inst (.CLK(CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_EVENT(SRC_EVENT), .CPU_IRQ(CPU_IRQ),
  .CPU_VECTOR(CPU_VECTOR), .RESTORE_VALID(RESTORE_VALID), .IRQ(IRQ));
`default_nettype wire

// *** dv/pric_core_model.sv ***
// Partner model: core program counter and peripheral event sources
`timescale 1ns/1ns
`default_nettype none
module pric_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] fire,
  input wire logic fire_trap,
  input wire logic [15:0] pc_set,
  output logic [7:0] src_event,
  output logic trap_event,
  output logic [15:0] core_pc
);
  // Events are one-cycle pulses; a held level would keep re-setting flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_event <= 8'h00;
      trap_event <= 1'b0;
      core_pc <= 16'h0000;
    end else begin
      src_event <= fire;
      trap_event <= fire_trap;
      core_pc <= pc_set;
    end
  end
endmodule
`default_nettype wire

// *** dv/pric_tb_top.sv ***
// Testbench: register, priority, masking and return checks of the controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch %0t value differs", $time); end end
module pric_tb_top;
  import pric_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fire_trap = 0;
  logic [7:0] paddr = 8'h00, fire = 8'h00, src_event;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [15:0] pc_set = 16'h0, core_pc, restore_pc;
  logic pready, pslverr, trap_event, cpu_irq, restore_valid, irq, girq = 0;
  logic [6:0] cpu_vector;
  logic [34:0] q[$];
  logic [15:0] rq[$], stk[$];
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #20 clk = ~clk;
  pric_top pric_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_EVENT(src_event), .TRAP_EVENT(trap_event), .CORE_PC(core_pc),
    .CPU_IRQ(cpu_irq), .CPU_VECTOR(cpu_vector), .RESTORE_PC(restore_pc),
    .RESTORE_VALID(restore_valid), .IRQ(irq));
  pric_core_model pric_core_model_inst (.clk(clk), .rst_n(rst_n), .fire(fire),
    .fire_trap(fire_trap), .pc_set(pc_set), .src_event(src_event),
    .trap_event(trap_event), .core_pc(core_pc));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
    input logic [34:0] x);
    @(posedge clk);
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, 35'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, {1'b1, girq, 1'b0, x});
  endtask
  task automatic ack();
    logic [15:0] p;
    p = 16'($urandom);
    pc_set <= p;
    stk.push_back(p);
    wr(PRIC_OFS_CMD, 32'h1);
  endtask
  task automatic ret();
    rq.push_back(stk.pop_back());
    wr(PRIC_OFS_CMD, 32'h2);
  endtask
  task automatic pulse(input logic [7:0] s, input logic t);
    @(posedge clk);
    fire <= s;
    fire_trap <= t;
    @(posedge clk);
    fire <= 8'h00;
    fire_trap <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wirq(input logic [6:0] v);
    int n;
    n = 0;
    while (cpu_irq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(cpu_irq, 1'b1)
    `CHK(cpu_vector, v)
  endtask
  task wrap_up();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Result watchers
  // --------------------------------------------------------------
  always @(negedge clk) begin
    if (pready === 1'b1) begin
      `CHK(pslverr, q[0][32])
      if (q[0][34]) `CHK(prdata, q[0][31:0])
      if (q[0][34]) `CHK(irq, q[0][33])
      void'(q.pop_front());
    end
    if (restore_valid === 1'b1) `CHK(restore_pc, rq.pop_front())
  end
  // Expected run is under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("mismatch %0t timeout", $time);
      wrap_up();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(47505));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(PRIC_OFS_SRC0 + 8'(4 * i), 32'h40);
    rd(PRIC_OFS_STAT, 32'h0);
    wr(PRIC_OFS_STAT, 32'hFFFFFFFF);
    rd(PRIC_OFS_STAT, 32'h0);
    xfer(1'b1, 8'hFC, 32'h1, 35'h100000000);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      wr(PRIC_OFS_SRC0 + 8'(4 * i), d);
      rd(PRIC_OFS_SRC0 + 8'(4 * i), d & 32'h70);
    end
    wr(PRIC_OFS_PRIO, 32'h0);
    wr(PRIC_OFS_FLAG, 32'h0);
    wr(PRIC_OFS_ENAB, 32'hFF);
    pulse(8'h01, 1'b0);
    rd(PRIC_OFS_FLAG, 32'h1);
    rd(PRIC_OFS_STAT, 32'h0);
    wr(PRIC_OFS_FLAG, 32'h0);
    wr(PRIC_OFS_SRC0 + 8'h0C, 32'h60);
    wr(PRIC_OFS_SRC0 + 8'h14, 32'h20);
    wr(PRIC_OFS_IMSK, 32'h1);
    pulse(8'h28, 1'b0);
    wirq(7'h0B);
    rd(PRIC_OFS_STAT, 32'h0603);
    ack();
    girq = 1;
    rd(PRIC_OFS_ISTS, 32'h1);
    wr(PRIC_OFS_ISTS, 32'h3);
    girq = 0;
    wr(PRIC_OFS_FLAG, 32'h20);
    ret();
    wirq(7'h0D);
    rd(PRIC_OFS_STAT, 32'h0205);
    ack();
    wr(PRIC_OFS_ISTS, 32'h3);
    ret();
    wirq(7'h0D);
    ack();
    girq = 1;
    rd(PRIC_OFS_ISTS, 32'h3);
    wr(PRIC_OFS_FLAG, 32'h0);
    ret();
    wr(PRIC_OFS_IMSK, 32'h0);
    girq = 0;
    wr(PRIC_OFS_SRC0 + 8'h0C, 32'h70);
    wr(PRIC_OFS_CPU, {24'h0, PRIC_MASK_OR});
    pulse(8'h08, 1'b0);
    rd(PRIC_OFS_STAT, 32'h0205);
    pulse(8'h00, 1'b1);
    wirq(7'h00);
    rd(PRIC_OFS_STAT, 32'h0F00);
    ack();
    wr(PRIC_OFS_CTRL, 32'h0);
    wr(PRIC_OFS_FLAG, 32'h0);
    ret();
    wr(PRIC_OFS_CPU, 32'h0);
    wr(PRIC_OFS_SRC0 + 8'h10, 32'h50);
    wr(PRIC_OFS_ISTS, 32'h3);
    wr(PRIC_OFS_CMD, 32'h00C80004);
    pulse(8'h10, 1'b0);
    rd(PRIC_OFS_STAT, 32'h0F00);
    pulse(8'h08, 1'b0);
    wirq(7'h0B);
    rd(PRIC_OFS_STAT, 32'h0703);
    ack();
    wr(PRIC_OFS_FLAG, 32'h10);
    ret();
    rd(PRIC_OFS_STAT, 32'h0703);
    wirq(7'h0C);
    rd(PRIC_OFS_STAT, 32'h0504);
    ack();
    wr(PRIC_OFS_CTRL, 32'h8000);
    pulse(8'h08, 1'b0);
    rd(PRIC_OFS_STAT, 32'h0504);
    wr(PRIC_OFS_FLAG, 32'h0);
    ret();
    // One shared level for all sources: the lowest index is served first
    for (int i = 0; i < 8; i++) wr(PRIC_OFS_SRC0 + 8'(4 * i), 32'h30);
    pulse(8'h84, 1'b0);
    wirq(7'h0A);
    rd(PRIC_OFS_STAT, 32'h0302);
    ack();
    wr(PRIC_OFS_FLAG, 32'h0);
    ret();
    wrap_up();
  end
endmodule
`default_nettype wire
